// file: inc/emb_pkg.sv
// Constants and types for the external muxed memory bus block
`default_nettype none
package emb_pkg;
   localparam logic [15:0] ROM_LO = 16'h2000;
   localparam logic [15:0] ROM_HI = 16'h2fff;
   localparam logic EXT_N_RESET = 1'b0;
   localparam int ADDR_CYCLES = 2;
   localparam int DATA_CYCLES = 2;
   localparam logic [1:0] CNT_ADDR_LAST = 2'(ADDR_CYCLES - 1);
   localparam logic [1:0] CNT_DATA_LAST = 2'(DATA_CYCLES - 1);
   typedef enum logic [1:0] {
      EMB_IDLE = 2'b00,
      EMB_ADDR = 2'b01,
      EMB_DATA = 2'b10
   } emb_state_t;
endpackage
`default_nettype wire

// file: logic/emb_route.sv
// On-chip or off-chip routing decision for one access address
`timescale 1ns/1ps
`default_nettype none
module emb_route (
   input wire logic [15:0] addr,
   input wire logic ext_latched_n,
   output logic off_chip
);
   always_comb begin
      if (!ext_latched_n) begin
         off_chip = 1'b1;
      end else begin
         off_chip = !((addr >= emb_pkg::ROM_LO) && (addr <= emb_pkg::ROM_HI));
      end
   end
endmodule
`default_nettype wire

// file: logic/emb_bus.sv
// External multiplexed address/data bus controller
// Overview of operation
// - Address-valid strobe low only during external accesses, never internal ones.
// - Address-valid stays low whole cycle, goes high when cycle ends.
// - Address latch strobe pulses high at start of each external cycle.
// - Latch strobe returns high only when next external cycle starts.
// - Address phase drives all sixteen address bits onto the muxed lines.
// - Data phase moves an 8-bit or 16-bit item per cycle width.
// - In 16-bit cycles upper byte enable low for word and high-byte.
// - Cycle width and req_bytes bit 1 together select which bytes move.
// - With dynamic width enabled, width input high means 16-bit cycle.
// - Width input is honoured also while fetching the configuration word.
// - Latched high sends 2000H to 2FFFH on chip, others off chip.
// - External-access input sampled only at reset release, then held.
`timescale 1ns/1ps
`default_nettype none
module emb_bus (
   input wire logic mclk,
   input wire logic rst,
   input wire logic external_access_n,
   input wire logic dynamic_width_sel,
   input wire logic cfg_dynamic_en,
   input wire logic cfg_wide,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_config,
   input wire logic [1:0] req_bytes,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic [7:0] muxed_bus_hi_in,
   input wire logic [7:0] muxed_bus_lo_in,
   output logic [7:0] muxed_bus_hi_out,
   output logic [7:0] muxed_bus_lo_out,
   output logic muxed_bus_oe,
   output logic address_valid_n,
   output logic addr_latch,
   output logic upper_byte_enable_n,
   output logic rd_n,
   output logic wr_n,
   output logic req_ready,
   output logic rsp_valid,
   output logic rsp_internal,
   output logic rsp_wide,
   output logic [15:0] rsp_rdata
);
   emb_pkg::emb_state_t st_q, st_d;
   logic [1:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic [7:0] hi_q, hi_d, lo_q, lo_d;
   logic oe_q, oe_d, adv_n_q, adv_n_d, ale_q, ale_d, ube_n_q, ube_n_d;
   logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, rdy_q, rdy_d, rv_q, rv_d;
   logic int_q, int_d, wide_q, wide_d, we_q, we_d;
   logic [1:0] bytes_q, bytes_d;
   logic ext_n_q, ext_n_d, rst_seen_q;
   logic off_chip;
   logic cyc_wide;

   emb_route u_route (
      .addr(req_addr),
      .ext_latched_n(ext_n_q),
      .off_chip(off_chip)
   );

   // Width chosen live; config fetch takes no special path so pin still rules
   assign cyc_wide = cfg_dynamic_en ? dynamic_width_sel : cfg_wide;

   // Strap caught in the first clocked cycle after reset releases
   always_comb begin
      ext_n_d = ext_n_q;
      if (rst_seen_q) begin
         ext_n_d = external_access_n;
      end
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      hi_d = hi_q;
      lo_d = lo_q;
      oe_d = oe_q;
      adv_n_d = adv_n_q;
      ale_d = ale_q;
      ube_n_d = ube_n_q;
      rd_n_d = 1'b1;
      wr_n_d = 1'b1;
      rdy_d = 1'b0;
      rv_d = 1'b0;
      int_d = int_q;
      wide_d = wide_q;
      we_d = we_q;
      bytes_d = bytes_q;
      unique case (st_q)
         emb_pkg::EMB_IDLE: begin
            rdy_d = 1'b1;
            if (req_valid && rdy_q) begin
               rdy_d = 1'b0;
               addr_d = req_addr;
               wdata_d = req_wdata;
               we_d = req_write;
               bytes_d = req_bytes;
               // Config fetch routes like any other access
               if (off_chip) begin
                  st_d = emb_pkg::EMB_ADDR;
                  cnt_d = 2'h0;
                  adv_n_d = 1'b0;
                  ale_d = 1'b1;
                  oe_d = 1'b1;
                  {hi_d, lo_d} = req_addr;
                  // Byte select: req_bytes bit 1 plus cycle width; 8-bit cycles never assert it
                  ube_n_d = !(cyc_wide && req_bytes[1]);
                  wide_d = cyc_wide;
               end else begin
                  // Internal access: strobes stay idle
                  rv_d = 1'b1;
                  int_d = 1'b1;
                  rdata_d = 16'h0000;
               end
            end
         end
         emb_pkg::EMB_ADDR: begin
            if (cnt_q == emb_pkg::CNT_ADDR_LAST) begin
               st_d = emb_pkg::EMB_DATA;
               cnt_d = 2'h0;
               ale_d = 1'b0;
               oe_d = we_q;
               {hi_d, lo_d} = wide_q ? wdata_q
                  : {8'h00, bytes_q[1] ? wdata_q[15:8] : wdata_q[7:0]};
               rd_n_d = we_q;
               wr_n_d = !we_q;
            end else begin
               cnt_d = 2'(cnt_q + 2'h1);
            end
         end
         emb_pkg::EMB_DATA: begin
            rd_n_d = we_q;
            wr_n_d = !we_q;
            if (cnt_q == emb_pkg::CNT_DATA_LAST) begin
               st_d = emb_pkg::EMB_IDLE;
               adv_n_d = 1'b1;
               ube_n_d = 1'b1;
               oe_d = 1'b0;
               rd_n_d = 1'b1;
               wr_n_d = 1'b1;
               rv_d = 1'b1;
               int_d = 1'b0;
               rdy_d = 1'b1;
               if (wide_q) begin
                  rdata_d = {muxed_bus_hi_in, muxed_bus_lo_in};
               end else begin
                  rdata_d = {8'h00, muxed_bus_lo_in};
               end
            end else begin
               cnt_d = 2'(cnt_q + 2'h1);
            end
         end
         default: begin
            st_d = emb_pkg::EMB_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= emb_pkg::EMB_IDLE;
         cnt_q <= 2'h0;
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         hi_q <= 8'h00;
         lo_q <= 8'h00;
         oe_q <= 1'b0;
         adv_n_q <= 1'b1;
         ale_q <= 1'b0;
         ube_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         rdy_q <= 1'b0;
         rv_q <= 1'b0;
         int_q <= 1'b0;
         wide_q <= 1'b0;
         we_q <= 1'b0;
         bytes_q <= 2'h0;
         ext_n_q <= emb_pkg::EXT_N_RESET;
         rst_seen_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
         oe_q <= oe_d;
         adv_n_q <= adv_n_d;
         ale_q <= ale_d;
         ube_n_q <= ube_n_d;
         rd_n_q <= rd_n_d;
         wr_n_q <= wr_n_d;
         rdy_q <= rdy_d;
         rv_q <= rv_d;
         int_q <= int_d;
         wide_q <= wide_d;
         we_q <= we_d;
         bytes_q <= bytes_d;
         ext_n_q <= ext_n_d;
         rst_seen_q <= 1'b0;
      end
   end

   assign muxed_bus_hi_out = hi_q;
   assign muxed_bus_lo_out = lo_q;
   assign muxed_bus_oe = oe_q;
   assign address_valid_n = adv_n_q;
   assign addr_latch = ale_q;
   assign upper_byte_enable_n = ube_n_q;
   assign rd_n = rd_n_q;
   assign wr_n = wr_n_q;
   assign req_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_internal = int_q;
   assign rsp_wide = wide_q;
   assign rsp_rdata = rdata_q;

   AST_ADV_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (st_q == emb_pkg::EMB_IDLE) |-> address_valid_n)
      else $error("address valid low outside an external cycle");
   AST_ADV_HOLD: assert property (@(posedge mclk) disable iff (rst)
      $fell(address_valid_n) |-> (!address_valid_n)[*4] ##1 address_valid_n)
      else $error("address valid not held for whole cycle");
   AST_ALE_START: assert property (@(posedge mclk) disable iff (rst)
      $fell(address_valid_n) |-> addr_latch)
      else $error("latch strobe missing at cycle start");
   AST_ALE_SHORT: assert property (@(posedge mclk) disable iff (rst)
      $rose(addr_latch) |-> addr_latch[*2] ##1 !addr_latch)
      else $error("latch strobe wrong length");
   AST_ADDR_OUT: assert property (@(posedge mclk) disable iff (rst)
      addr_latch |-> ({muxed_bus_hi_out, muxed_bus_lo_out} == addr_q && muxed_bus_oe))
      else $error("address not on bus in address phase");
   AST_UBE_NARROW: assert property (@(posedge mclk) disable iff (rst)
      (!address_valid_n && !wide_q) |-> upper_byte_enable_n)
      else $error("upper byte enable in 8-bit cycle");
   AST_INTERNAL: assert property (@(posedge mclk) disable iff (rst)
      (rsp_valid && rsp_internal) |-> (address_valid_n && !addr_latch))
      else $error("strobes active on internal access");
   // Capture edge and the one after it are skipped: the strap legally moves there
   AST_STRAP: assert property (@(posedge mclk) disable iff (rst)
      (!rst_seen_q && !$past(rst_seen_q)) |-> $stable(ext_n_q))
      else $error("external access strap changed after reset");
endmodule
`default_nettype wire

// file: tb/emb_mem_model.sv
// Behavioural external memory with address latch
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
   input wire logic mclk,
   input wire logic addr_latch,
   input wire logic rd_n,
   input wire logic [7:0] bus_hi,
   input wire logic [7:0] bus_lo,
   output logic [7:0] rd_hi,
   output logic [7:0] rd_lo,
   output logic [15:0] lat_addr
);
   logic [7:0] fill_q = 8'h00;
   always @(posedge mclk) begin
      fill_q <= fill_q + 8'h3b;
      if (addr_latch) begin
         lat_addr <= {bus_hi, bus_lo};
      end
   end
   // Released bus moves every cycle so stale data cannot pass
   assign rd_hi = !rd_n ? lat_addr[15:8] ^ 8'h5a : fill_q;
   assign rd_lo = !rd_n ? lat_addr[7:0] ^ 8'ha5 : ~fill_q;
endmodule
`default_nettype wire

// file: tb/test_external_muxed_memory_bus.sv
// Self-checking bench for the external muxed memory bus
`timescale 1ns/1ps
`default_nettype none
module test_external_muxed_memory_bus;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic external_access_n = 1'b0, dynamic_width_sel = 1'b0, cfg_dynamic_en = 1'b0;
   logic cfg_wide = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_config = 1'b0;
   logic [1:0] req_bytes = 2'h3;
   logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
   logic [7:0] muxed_bus_hi_in, muxed_bus_lo_in, muxed_bus_hi_out, muxed_bus_lo_out;
   logic muxed_bus_oe, address_valid_n, addr_latch, upper_byte_enable_n, rd_n, wr_n;
   logic req_ready, rsp_valid, rsp_internal, rsp_wide, strap_m;
   logic [15:0] rsp_rdata, lat_addr, a;
   int err_count = 0, n_tests = 0, seed = 32'hfbf8, i;
   // Reference model: expected read data queued at request, drained at response
   logic [15:0] exp_q[$];
   emb_bus uut (.mclk, .rst, .external_access_n, .dynamic_width_sel, .cfg_dynamic_en,
      .cfg_wide, .req_valid, .req_write, .req_config, .req_bytes, .req_addr, .req_wdata,
      .muxed_bus_hi_in, .muxed_bus_lo_in, .muxed_bus_hi_out, .muxed_bus_lo_out,
      .muxed_bus_oe, .address_valid_n, .addr_latch, .upper_byte_enable_n, .rd_n, .wr_n,
      .req_ready, .rsp_valid, .rsp_internal, .rsp_wide, .rsp_rdata);
   emb_mem_model mem (.mclk, .addr_latch, .rd_n, .bus_hi(muxed_bus_hi_out),
      .bus_lo(muxed_bus_lo_out), .rd_hi(muxed_bus_hi_in), .rd_lo(muxed_bus_lo_in), .lat_addr);
   always #2 mclk = ~mclk;
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset(input logic s);
      rst = 1'b1;
      external_access_n = s;
      strap_m = s;
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      // Strap flips after capture; the routing must not follow it
      external_access_n = ~s;
   endtask
   task automatic access(input logic [15:0] ad, input logic w, input logic [1:0] b);
      logic intern, wide, ube;
      logic [15:0] wd, bus_wd;
      int k, adv, stb, bad;
      k = 0;
      while (req_ready !== 1'b1 && k < 20) begin
         @(negedge mclk);
         k++;
      end
      if (req_ready !== 1'b1) begin
         err_count++;
         report_and_stop;
      end
      wd = 16'($random(seed));
      dynamic_width_sel = wd[3];
      intern = strap_m && ad >= 16'h2000 && ad <= 16'h2fff;
      wide = cfg_dynamic_en ? wd[3] : cfg_wide;
      {req_valid, req_write, req_addr, req_bytes, req_wdata} = {1'b1, w, ad, b, wd};
      req_config = wd[7] & ~w;
      if (!w) begin
         exp_q.push_back(intern ? 16'h0 : wide ? ad ^ 16'h5aa5 : {8'h00, ad[7:0] ^ 8'ha5});
      end
      @(negedge mclk);
      req_valid = 1'b0;
      adv = 0;
      stb = 0;
      bad = 0;
      ube = 1'b1;
      bus_wd = 16'h0000;
      for (k = 0; k < 20 && rsp_valid !== 1'b1; k++) begin
         if (address_valid_n === 1'b0) begin
            adv++;
            ube = upper_byte_enable_n;
         end
         if (wr_n === 1'b0) begin
            bus_wd = {muxed_bus_hi_out, muxed_bus_lo_out};
         end
         if ((w ? wr_n : rd_n) === 1'b0) begin
            stb++;
         end
         // Wrong strobe, or bus driven while the far side answers a read
         if ((w ? rd_n : wr_n) !== 1'b1 || (rd_n === 1'b0 && muxed_bus_oe !== 1'b0)
            || (wr_n === 1'b0 && muxed_bus_oe !== 1'b1)) begin
            bad++;
         end
         @(negedge mclk);
      end
      check("response", 16'(rsp_valid), 16'h0001);
      if (rsp_valid !== 1'b1) begin
         report_and_stop;
      end
      check("data strobe", 16'(stb), intern ? 16'h0 : 16'(emb_pkg::DATA_CYCLES));
      check("strobe or drive fault", 16'(bad), 16'h0);
      check("internal", 16'(rsp_internal), 16'(intern));
      check("adv cycles", 16'(adv), intern ? 16'h0 : 16'(4));
      check("adv end", 16'(address_valid_n), 16'h0001);
      if (!intern) begin
         check("width", 16'(rsp_wide), 16'(wide));
         check("address", lat_addr, ad);
         check("ube", 16'(ube), 16'(!(wide && b[1])));
         if (w && wide) begin
            check("wdata", bus_wd, wd);
         end else if (w) begin
            check("wdata narrow", bus_wd, {8'h00, b[1] ? wd[15:8] : wd[7:0]});
         end
      end
      if (!w) begin
         check("rdata", rsp_rdata, exp_q.pop_front());
      end
   endtask
   initial begin
      do_reset(1'b1);
      for (i = 0; i < 48; i++) begin
         {cfg_dynamic_en, cfg_wide} = 2'(i);
         a = 16'($random(seed));
         if (i < 8) begin
            a = i[2] ? {3'h1, i[1], {12{i[0]}}} : {4'h2, {12{i[0]}}};
         end else if (i[2]) begin
            a[15:12] = 4'h2;
         end
         access(a, a[5], a[9:8] | 2'h1);
      end
      do_reset(1'b0);
      for (i = 0; i < 16; i++) begin
         {cfg_dynamic_en, cfg_wide} = 2'(i);
         a = {4'h2, 12'($random(seed))};
         access(a, i[2], 2'h3);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
